/* verilog/rmsc_defines.vh */
// offsets, field positions, reset values and timing counts of the mode controller
`ifndef RMSC_DEFINES_VH
`define RMSC_DEFINES_VH
// register byte offsets
`define RMSC_OFS_CONFIG 5'h00
`define RMSC_OFS_CHANNEL 5'h04
`define RMSC_OFS_SETUP 5'h08
`define RMSC_OFS_RETRY 5'h0c
`define RMSC_OFS_STATUS 5'h10
`define RMSC_OFS_CMD 5'h14
`define RMSC_OFS_FREQ 5'h18
// config fields
`define RMSC_CFG_PWR 0
`define RMSC_CFG_ROLE 1
`define RMSC_CFG_AA 2
// setup fields
`define RMSC_SET_PWR_LO 1
`define RMSC_SET_PWR_HI 2
`define RMSC_SET_RATE_UP 3
`define RMSC_SET_RATE_LO 5
// status fields
`define RMSC_ST_SENT 0
`define RMSC_ST_EXH 1
`define RMSC_ST_DROP 2
`define RMSC_ST_CS 3
// command fields
`define RMSC_CMD_PUSH 0
`define RMSC_CMD_PUSH_NOACK 1
`define RMSC_CMD_POP_RX 2
// reset values
`define RMSC_RST_CONFIG 3'h4
`define RMSC_RST_CHANNEL 7'h02
`define RMSC_RST_SETUP 8'h06
`define RMSC_RST_RETRY 8'h03
// fifo depth in slots
`define RMSC_SLOTS 2'h3
// carrier base frequency in MHz
`define RMSC_BASE_MHZ 12'h960
// timing
`define RMSC_CLK_NS 25
`define RMSC_CE_MIN_NS 10000
`define RMSC_CE_CYC ((`RMSC_CE_MIN_NS + `RMSC_CLK_NS - 1) / `RMSC_CLK_NS)
`define RMSC_CS_MIN_NS 128000
`define RMSC_CS_CYC ((`RMSC_CS_MIN_NS + `RMSC_CLK_NS - 1) / `RMSC_CLK_NS)
`define RMSC_RD_STEP_NS 250000
`define RMSC_RD_STEP_CYC (`RMSC_RD_STEP_NS / `RMSC_CLK_NS)
`endif

/* verilog/rmsc_top.v */
// radio mode state controller with avalon register slave
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "rmsc_defines.vh"

// Behaviour
// - carrier frequency is 2400 plus channel MHz
// - rate bits pick 250k, 1M or 2M
// - power bit clear enters power down
// - registers stay accessible in power down
// - powered with activate low sits standby-I, but a pending retry still transmits
// - activate low in tx/rx returns standby-I
// - transmitter, activate high, empty fifo: standby-II
// - payload load in standby-II starts transmit
// - transmit needs power, tx role, payload, long pulse
// - transmit finishes packet, then standby-I if low
// - activate high: next packet or standby-II
// - retry after delay while retries below limit
// - await ack only with auto-ack and ack wanted
// - receiver acks only with auto-ack, ack wanted
// - receive needs power, rx role, activate high
// - receiver returns to receive after ack sent
// - receive stores valid packets in free slot
// - full receive fifo drops packet
// - receiver stays receiving until host moves it
// - carrier sense after 128 us energy
// - auto-ack off: no automatic turnarounds
// - skip-ack packet is never acknowledged
// - retries exhausted set flag and interrupt
// - unacked payload ends at tx done, no ack wait
module rmsc_top #(
    parameter CS_CYC = `RMSC_CS_CYC,
    parameter RD_STEP_CYC = `RMSC_RD_STEP_CYC
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // pins and packet engine events
    input wire ce,
    input wire rf_energy,
    input wire tx_done,
    input wire ack_rcvd,
    input wire ack_timeout,
    input wire pkt_valid,
    input wire pkt_noack,
    // radio controls and status
    output reg [2:0] radio_state,
    output reg [11:0] freq_mhz,
    output reg [1:0] rate_code,
    output reg [1:0] tx_power_level,
    output reg rx_store,
    output reg irq_n
);
    // mode states
    localparam [2:0] S_PDN = 3'd0;
    localparam [2:0] S_SB1 = 3'd1;
    localparam [2:0] S_SB2 = 3'd2;
    localparam [2:0] S_TX = 3'd3;
    localparam [2:0] S_RX = 3'd4;

    // reset release synchroniser
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_i_n = rst_s2_q;

    // registers
    reg [2:0] cfg_q; // power, role, auto-ack
    reg [6:0] chan_q; // channel_select
    reg [7:0] setup_q; // radio_setup
    reg [7:0] retry_q; // retry_delay high nibble, retry_limit low nibble
    reg sent_q; // sent_flag
    reg exh_q; // retry_exhausted_flag
    reg drop_q; // receive drop flag
    reg cs_q; // carrier_sense
    reg [3:0] rcnt_q; // retry_counter
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [1:0] txc_q; // tx slots used
    reg [1:0] txc_d;
    reg [2:0] txna_q; // per slot skip-ack, head at bit 0
    reg [2:0] txna_d;
    reg [1:0] rxc_q; // rx slots used
    reg ack_q; // bus answer phase

    wire pwr = cfg_q[`RMSC_CFG_PWR];
    wire role_rx = cfg_q[`RMSC_CFG_ROLE];
    wire aa = cfg_q[`RMSC_CFG_AA];
    wire [3:0] retry_limit = retry_q[3:0];
    wire [3:0] retry_delay = retry_q[7:4];

    // bus handshake: one wait cycle, then answer
    wire req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    wire wr = avs_write & ack_q & avs_byteenable[0];
    wire wr_cfg = wr & (avs_address == `RMSC_OFS_CONFIG);
    wire wr_cmd = wr & (avs_address == `RMSC_OFS_CMD);
    wire wr_st = wr & (avs_address == `RMSC_OFS_STATUS);
    wire push = wr_cmd & (avs_writedata[`RMSC_CMD_PUSH] | avs_writedata[`RMSC_CMD_PUSH_NOACK])
        & (txc_q != `RMSC_SLOTS);
    wire pop_rx = wr_cmd & avs_writedata[`RMSC_CMD_POP_RX] & (rxc_q != 2'd0);

    // activate pin sync and pulse width count
    reg ce_s1_q;
    reg ce_s2_q;
    reg [8:0] ce_cnt_q;
    wire ce_long = (ce_cnt_q > `RMSC_CE_CYC);
    always @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ce_s1_q <= 1'b0;
            ce_s2_q <= 1'b0;
            ce_cnt_q <= 9'h000;
        end else begin
            ce_s1_q <= ce;
            ce_s2_q <= ce_s1_q;
            // count high time, saturate just past the minimum
            if (!ce_s2_q)
                ce_cnt_q <= 9'h000;
            else if (!ce_long)
                ce_cnt_q <= ce_cnt_q + 9'h001;
        end
    end

    // retry delay timer
    reg rp_q; // retry pending
    reg [17:0] rd_tmr_q;
    reg [4:0] rd_step_q;
    wire rd_elapsed = rp_q & (rd_step_q == ({1'b0, retry_delay} + 5'd1));

    // next state and fifo events
    reg pop_tx;
    reg set_sent;
    reg set_exh;
    reg start_rp;
    reg retry_go;
    reg rx_push;
    reg rx_drop;
    reg clr_rcnt;
    reg [2:0] ptx_next;
    always @* begin
        st_d = st_q;
        pop_tx = 1'b0;
        set_sent = 1'b0;
        set_exh = 1'b0;
        start_rp = 1'b0;
        retry_go = 1'b0;
        rx_push = 1'b0;
        rx_drop = 1'b0;
        clr_rcnt = 1'b0;
        // after a delivered packet: standby-I, next packet or standby-II
        if (!ce_s2_q)
            ptx_next = S_SB1;
        else if (txc_q > 2'd1)
            ptx_next = S_TX;
        else
            ptx_next = S_SB2;
        if (!pwr) begin
            st_d = S_PDN;
        end else begin
            case (st_q)
                S_PDN: begin
                    st_d = S_SB1;
                end
                S_SB1: begin
                    if (role_rx) begin
                        if (ce_s2_q)
                            st_d = S_RX;
                    end else if (rp_q) begin
                        if (rd_elapsed) begin
                            st_d = S_TX;
                            retry_go = 1'b1;
                        end
                    end else if (txc_q != 2'd0 && ce_long && !exh_q) begin
                        st_d = S_TX;
                        clr_rcnt = 1'b1;
                    end else if (ce_s2_q && txc_q == 2'd0) begin
                        st_d = S_SB2;
                    end
                end
                S_SB2: begin
                    if (!ce_s2_q || role_rx)
                        st_d = S_SB1;
                    else if (txc_q != 2'd0) begin
                        st_d = S_TX;
                        clr_rcnt = 1'b1;
                    end
                end
                S_TX: begin
                    // the packet completes before leaving unless the power bit is cleared
                    if (tx_done) begin
                        if (role_rx) begin
                            // ack sent, carrying a pending payload if any
                            pop_tx = (txc_q != 2'd0);
                            st_d = ce_s2_q ? S_RX : S_SB1;
                        end else if (aa && !txna_q[0]) begin
                            st_d = S_RX;
                        end else begin
                            // unacked or auto-ack off: done at once
                            pop_tx = 1'b1;
                            set_sent = 1'b1;
                            st_d = ce_s2_q ? ptx_next : S_SB1;
                        end
                    end
                end
                S_RX: begin
                    if (!ce_s2_q) begin
                        st_d = S_SB1;
                    end else if (!role_rx) begin
                        // transmitter awaiting acknowledgement
                        if (ack_rcvd) begin
                            pop_tx = 1'b1;
                            set_sent = 1'b1;
                            st_d = ptx_next;
                        end else if (ack_timeout) begin
                            st_d = S_SB1;
                            if (rcnt_q < retry_limit)
                                start_rp = 1'b1;
                            else
                                set_exh = 1'b1;
                        end
                    end else if (pkt_valid) begin
                        rx_push = (rxc_q != `RMSC_SLOTS);
                        rx_drop = (rxc_q == `RMSC_SLOTS);
                        if (aa && !pkt_noack)
                            st_d = S_TX;
                    end
                end
                default: begin
                    st_d = S_PDN;
                end
            endcase
        end
    end

    // tx slot queue: pop shifts, push appends
    always @* begin
        txc_d = txc_q;
        txna_d = txna_q;
        if (pop_tx) begin
            txna_d = {1'b0, txna_d[2:1]};
            txc_d = txc_d - 2'd1;
        end
        if (push) begin
            txna_d[txc_d] = avs_writedata[`RMSC_CMD_PUSH_NOACK];
            txc_d = txc_d + 2'd1;
        end
    end

    // core state, queues, flags and retry timing
    always @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            st_q <= S_PDN;
            txc_q <= 2'd0;
            txna_q <= 3'h0;
            rxc_q <= 2'd0;
            sent_q <= 1'b0;
            exh_q <= 1'b0;
            drop_q <= 1'b0;
            rcnt_q <= 4'h0;
            rp_q <= 1'b0;
            rd_tmr_q <= 18'h0_0000;
            rd_step_q <= 5'h00;
        end else begin
            st_q <= st_d;
            txc_q <= txc_d;
            txna_q <= txna_d;
            rxc_q <= rxc_q + {1'b0, rx_push} - {1'b0, pop_rx};
            // sticky flags, a new event beats a clear
            sent_q <= set_sent | (sent_q & ~(wr_st & avs_writedata[`RMSC_ST_SENT]));
            exh_q <= set_exh | (exh_q & ~(wr_st & avs_writedata[`RMSC_ST_EXH]));
            drop_q <= rx_drop | (drop_q & ~(wr_st & avs_writedata[`RMSC_ST_DROP]));
            // retries per transaction
            if (clr_rcnt)
                rcnt_q <= 4'h0;
            else if (retry_go)
                rcnt_q <= rcnt_q + 4'h1;
            // delay counts in steps while pending in standby-I
            if (start_rp) begin
                rp_q <= 1'b1;
                rd_tmr_q <= 18'h0_0000;
                rd_step_q <= 5'h00;
            end else if (retry_go || st_q != S_SB1) begin
                rp_q <= 1'b0;
            end else if (rp_q && !rd_elapsed) begin
                if (rd_tmr_q == RD_STEP_CYC[17:0] - 18'h0_0001) begin
                    rd_tmr_q <= 18'h0_0000;
                    rd_step_q <= rd_step_q + 5'h01;
                end else begin
                    rd_tmr_q <= rd_tmr_q + 18'h0_0001;
                end
            end
        end
    end

    // carrier sense filter, only in receive
    reg [12:0] cs_cnt_q;
    always @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cs_cnt_q <= 13'h0000;
            cs_q <= 1'b0;
        end else if (st_q != S_RX || !rf_energy) begin
            cs_cnt_q <= 13'h0000;
            cs_q <= 1'b0;
        end else if (cs_cnt_q == CS_CYC[12:0] - 13'h0001) begin
            cs_q <= 1'b1;
        end else begin
            cs_cnt_q <= cs_cnt_q + 13'h0001;
        end
    end

    // configuration registers, written in any state
    always @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cfg_q <= `RMSC_RST_CONFIG;
            chan_q <= `RMSC_RST_CHANNEL;
            setup_q <= `RMSC_RST_SETUP;
            retry_q <= `RMSC_RST_RETRY;
        end else begin
            if (wr_cfg)
                cfg_q <= avs_writedata[2:0];
            if (wr && avs_address == `RMSC_OFS_CHANNEL)
                chan_q <= avs_writedata[6:0];
            if (wr && avs_address == `RMSC_OFS_SETUP)
                setup_q <= avs_writedata[7:0];
            if (wr && avs_address == `RMSC_OFS_RETRY)
                retry_q <= avs_writedata[7:0];
        end
    end

    // read mux, captured on the waiting cycle
    reg [31:0] rd_mux;
    always @* begin
        case (avs_address)
            `RMSC_OFS_CONFIG: rd_mux = {29'h0, cfg_q};
            `RMSC_OFS_CHANNEL: rd_mux = {25'h0, chan_q};
            `RMSC_OFS_SETUP: rd_mux = {24'h0, setup_q};
            `RMSC_OFS_RETRY: rd_mux = {24'h0, retry_q};
            `RMSC_OFS_STATUS: rd_mux = {16'h0, rxc_q, txc_q, 1'b0, st_q, rcnt_q,
                cs_q, drop_q, exh_q, sent_q};
            `RMSC_OFS_FREQ: rd_mux = {20'h0, freq_mhz};
            default: rd_mux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // bus slave and registered outputs
    always @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            radio_state <= S_PDN;
            freq_mhz <= `RMSC_BASE_MHZ;
            rate_code <= 2'd0;
            tx_power_level <= 2'd0;
            rx_store <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read && !ack_q)
                avs_readdata <= rd_mux;
            radio_state <= st_q;
            freq_mhz <= `RMSC_BASE_MHZ + {5'h00, chan_q};
            // 00 1M, 01 2M, 1x 250k
            if (setup_q[`RMSC_SET_RATE_LO])
                rate_code <= 2'd2;
            else
                rate_code <= {1'b0, setup_q[`RMSC_SET_RATE_UP]};
            tx_power_level <= setup_q[`RMSC_SET_PWR_HI:`RMSC_SET_PWR_LO];
            rx_store <= rx_push;
            irq_n <= ~(sent_q | exh_q | (rxc_q != 2'd0));
        end
    end
endmodule // rmsc_top

/* tb/rmsc_props.sv */
// port-level checks of the radio mode controller
`timescale 1ns/100ps
module rmsc_props #(
    parameter CS_CYC = 8,
    parameter RD_STEP_CYC = 4
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // register bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    // pin and packet events
    input wire ce,
    input wire ack_rcvd,
    input wire pkt_valid,
    input wire pkt_noack,
    // radio outputs
    input wire [2:0] radio_state,
    input wire [11:0] freq_mhz,
    input wire [1:0] rate_code,
    input wire rx_store,
    input wire irq_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("new access got no wait cycle");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("access waited more than one cycle");
    a_freq_range: assert property (freq_mhz >= 12'h0960 && freq_mhz <= 12'h09df)
        else $error("carrier outside channel span");
    a_rate_legal: assert property (rate_code != 2'h3) else $error("bad rate code");
    a_state_legal: assert property (radio_state <= 3'h4) else $error("bad state");
    a_tx_entry: assert property (radio_state == 3'h3 && $past(radio_state) != 3'h3
        |-> $past(radio_state) inside {3'h1, 3'h2, 3'h4}) else $error("transmit from wrong state");
    a_rx_ce_low: assert property (!ce [*5] |=> radio_state != 3'h4)
        else $error("receive kept with activate low");
    a_ack_needs_pkt: assert property (radio_state == 3'h3 && $past(radio_state) == 3'h4
        |-> $past((pkt_valid && !pkt_noack) || ack_rcvd, 2))
        else $error("transmit after receive without a cause");
    a_sb2_needs_ce: assert property (radio_state == 3'h2 && $past(radio_state) != 3'h2
        |-> $past(ce, 4)) else $error("standby-II with activate low");
    a_store_in_rx: assert property (rx_store |-> $past(radio_state) == 3'h4)
        else $error("store outside receive");
    a_irq_store: assert property (rx_store |-> ##[0:2] !irq_n)
        else $error("stored packet raised no interrupt");
endmodule // rmsc_props

bind rmsc_top rmsc_props #(.CS_CYC(CS_CYC), .RD_STEP_CYC(RD_STEP_CYC)) rmsc_props_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .ce(ce), .ack_rcvd(ack_rcvd),
    .pkt_valid(pkt_valid), .pkt_noack(pkt_noack),
    .radio_state(radio_state), .freq_mhz(freq_mhz), .rate_code(rate_code),
    .rx_store(rx_store), .irq_n(irq_n));

/* tb/rmsc_radio_model.sv */
// packet engine model that answers the mode controller
`timescale 1ns/100ps
module rmsc_radio_model (
    // clock and observed state
    input wire ref_clk,
    input wire [2:0] radio_state,
    // bench controls
    input wire primary_receiver,
    input wire nak,
    input wire pkt_go,
    input wire pkt_skip,
    // engine events
    output reg tx_done,
    output reg ack_rcvd,
    output reg ack_timeout,
    output reg pkt_valid,
    output reg pkt_noack
);
    reg [2:0] last_q = 3'h0; // state of last cycle
    reg [3:0] cnt_q = 4'h0; // cycles spent in state
    initial begin
        {tx_done, ack_rcvd, ack_timeout, pkt_valid, pkt_noack} = 5'h00;
    end
    // time each state, fire one event at a fixed point
    always @(posedge ref_clk) begin
        last_q <= radio_state;
        // restart on a state change or a finished packet, so back to back sends finish too
        cnt_q <= (radio_state != last_q || tx_done) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
        // packet sent long before the transmit time limit
        tx_done <= radio_state == 3'h3 && cnt_q == 4'h6;
        ack_rcvd <= radio_state == 3'h4 && !primary_receiver && !nak && cnt_q == 4'h6;
        ack_timeout <= radio_state == 3'h4 && !primary_receiver && nak && cnt_q == 4'h6;
        pkt_valid <= pkt_go;
        pkt_noack <= pkt_go && pkt_skip;
    end
endmodule // rmsc_radio_model

/* tb/radio_mode_state_controller_bench.sv */
// self-checking bench of the radio mode controller
`timescale 1ns/100ps
`include "rmsc_defines.vh"
module radio_mode_state_controller_bench;
    reg ref_clk = 1'b0; // bus clock
    reg rst_n = 1'b0; // reset held at start
    reg [4:0] avs_address = 5'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0000_0000;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    reg ce = 1'b0; // activate pin
    reg rf_energy = 1'b0;
    reg primary_receiver = 1'b0, nak = 1'b0, pkt_go = 1'b0, pkt_skip = 1'b0; // model controls
    wire tx_done, ack_rcvd, ack_timeout, pkt_valid, pkt_noack;
    wire [2:0] radio_state;
    wire [11:0] freq_mhz;
    wire [1:0] rate_code, tx_power_level;
    wire rx_store, irq_n;
    integer err_count = 0, cmp_count = 0, stores = 0;
    reg [31:0] rd; // last read word

    always #12.5 ref_clk = ~ref_clk;

    rmsc_top #(.CS_CYC(8), .RD_STEP_CYC(4)) rmsc_top_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ce(ce),
        .rf_energy(rf_energy), .tx_done(tx_done), .ack_rcvd(ack_rcvd),
        .ack_timeout(ack_timeout), .pkt_valid(pkt_valid), .pkt_noack(pkt_noack),
        .radio_state(radio_state), .freq_mhz(freq_mhz), .rate_code(rate_code),
        .tx_power_level(tx_power_level), .rx_store(rx_store), .irq_n(irq_n));

    rmsc_radio_model rmsc_radio_model_inst (
        .ref_clk(ref_clk), .radio_state(radio_state), .primary_receiver(primary_receiver), .nak(nak), .pkt_go(pkt_go),
        .pkt_skip(pkt_skip), .tx_done(tx_done), .ack_rcvd(ack_rcvd),
        .ack_timeout(ack_timeout), .pkt_valid(pkt_valid), .pkt_noack(pkt_noack));

    // count stored packets
    always @(posedge ref_clk) if (rx_store === 1'b1) stores = stores + 1;

    task report_and_stop;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk_word(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: word %h not %h", $time, got, exp);
            end
        end
    endtask
    task chk_state(input [2:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (radio_state !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: state %h not %h", $time, radio_state, exp);
            end
        end
    endtask
    // bus cycles hold until waitrequest is sampled low
    task av_write(input [4:0] a, input [31:0] d);
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= 1'b1;
            do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
            avs_write <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task rd_chk(input [4:0] a, input [31:0] m, input [31:0] e);
        begin
            avs_address <= a;
            avs_read <= 1'b1;
            do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
            rd = avs_readdata;
            avs_read <= 1'b0;
            @(posedge ref_clk);
            chk_word(rd & m, e);
        end
    endtask
    task wait_state(input [2:0] s);
        integer n;
        begin
            n = 0;
            while (radio_state !== s && n < 2000) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            chk_state(s);
        end
    endtask
    task rate_chk(input [7:0] d, input [3:0] e);
        begin
            av_write(`RMSC_OFS_SETUP, {24'h0, d});
            repeat (2) @(posedge ref_clk);
            chk_word({28'h0, tx_power_level, rate_code}, {28'h0, e});
        end
    endtask
    task pkt(input s);
        begin
            pkt_skip <= s;
            pkt_go <= 1'b1;
            @(posedge ref_clk);
            pkt_go <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count = err_count + 1;
        $display("unexpected at %0t: run timed out", $time);
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(`RMSC_OFS_CONFIG, 32'hffff_ffff, 8'h04);
        rd_chk(`RMSC_OFS_CHANNEL, 32'hffff_ffff, 8'h02);
        rd_chk(`RMSC_OFS_SETUP, 32'hffff_ffff, 8'h06);
        rd_chk(`RMSC_OFS_RETRY, 32'hffff_ffff, 8'h03);
        rd_chk(5'h1c, 32'hffff_ffff, 8'h00);
        chk_state(3'h0);
        chk_word({31'h0, irq_n}, 32'h0000_0001);
        av_write(`RMSC_OFS_CHANNEL, 8'h7f);
        rd_chk(`RMSC_OFS_FREQ, 32'hffff_ffff, 16'h09df);
        chk_word({20'h0, freq_mhz}, 16'h09df);
        rate_chk(8'h02, 4'h4);
        rate_chk(8'h0c, 4'h9);
        rate_chk(8'h26, 4'he);
        av_write(`RMSC_OFS_RETRY, 8'h01);
        av_write(`RMSC_OFS_CONFIG, 8'h05);
        wait_state(3'h1);
        // short activate pulse must not start a packet
        av_write(`RMSC_OFS_CMD, 8'h01);
        ce <= 1'b1;
        repeat (100) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk_state(3'h1);
        av_write(`RMSC_OFS_CMD, 8'h01);
        ce <= 1'b1;
        wait_state(3'h3);
        wait_state(3'h4);
        wait_state(3'h3);
        wait_state(3'h4);
        wait_state(3'h2);
        rd_chk(`RMSC_OFS_STATUS, 8'h01, 8'h01);
        chk_word({31'h0, irq_n}, 8'h00);
        av_write(`RMSC_OFS_STATUS, 8'h01);
        av_write(`RMSC_OFS_CMD, 8'h01);
        wait_state(3'h3);
        wait_state(3'h2);
        ce <= 1'b0;
        wait_state(3'h1);
        av_write(`RMSC_OFS_STATUS, 8'h01);
        av_write(`RMSC_OFS_CMD, 8'h02);
        ce <= 1'b1;
        wait_state(3'h3);
        ce <= 1'b0;
        wait_state(3'h1);
        rd_chk(`RMSC_OFS_STATUS, 8'h01, 8'h01);
        // no acknowledgement ever comes back
        nak <= 1'b1;
        av_write(`RMSC_OFS_STATUS, 8'h01);
        av_write(`RMSC_OFS_CMD, 8'h01);
        ce <= 1'b1;
        wait_state(3'h4);
        wait_state(3'h1);
        wait_state(3'h3);
        wait_state(3'h4);
        wait_state(3'h1);
        rd_chk(`RMSC_OFS_STATUS, 8'hf2, 8'h12);
        chk_word({31'h0, irq_n}, 8'h00);
        ce <= 1'b0;
        av_write(`RMSC_OFS_STATUS, 8'h02);
        rd_chk(`RMSC_OFS_STATUS, 8'h02, 8'h00);
        // receiver role
        nak <= 1'b0;
        primary_receiver <= 1'b1;
        av_write(`RMSC_OFS_CONFIG, 8'h07);
        ce <= 1'b1;
        wait_state(3'h4);
        pkt(1'b0);
        wait_state(3'h3);
        wait_state(3'h4);
        pkt(1'b1);
        pkt(1'b1);
        chk_state(3'h4);
        rd_chk(`RMSC_OFS_STATUS, 16'hc000, 16'hc000);
        pkt(1'b1);
        rd_chk(`RMSC_OFS_STATUS, 8'h04, 8'h04);
        chk_word(stores, 8'h03);
        ce <= 1'b0;
        wait_state(3'h1);
        // auto-ack off: no turnaround, carrier sense filtered
        av_write(`RMSC_OFS_CONFIG, 8'h03);
        av_write(`RMSC_OFS_CMD, 8'h04);
        ce <= 1'b1;
        wait_state(3'h4);
        rf_energy <= 1'b1;
        rd_chk(`RMSC_OFS_STATUS, 8'h08, 8'h00);
        repeat (12) @(posedge ref_clk);
        rd_chk(`RMSC_OFS_STATUS, 8'h08, 8'h08);
        pkt(1'b0);
        repeat (8) @(posedge ref_clk);
        chk_state(3'h4);
        rf_energy <= 1'b0;
        av_write(`RMSC_OFS_CONFIG, 8'h00);
        wait_state(3'h0);
        rd_chk(`RMSC_OFS_CONFIG, 32'hffff_ffff, 8'h00);
        report_and_stop;
    end
endmodule // radio_mode_state_controller_bench
